// [pdc_pkg.sv]
// package of register addresses, field layouts and reset values for the packet data compare trap
`default_nettype none
package pdc_pkg;
   localparam int           PDC_ADDR_W      = 32;
   localparam int           PDC_REG_W       = 64;
   localparam int           PDC_PAT_W       = 81;
   localparam int           PDC_HALF_LO_W   = 45;
   localparam int           PDC_HALF_HI_W   = 36;
   localparam int           PDC_NUM_SRC     = 2;
   // msr addresses
   localparam logic [31:0]  PDC_VAL_LO_ADDR  = 32'h510100d0;
   localparam logic [31:0]  PDC_VAL_HI_ADDR  = 32'h510100d1;
   localparam logic [31:0]  PDC_MASK_LO_ADDR = 32'h510100d2;
   localparam logic [31:0]  PDC_MASK_HI_ADDR = 32'h510100d3;
   // field positions
   localparam int           PDC_LO_FIELD_MSB = 44;
   localparam int           PDC_HI_FIELD_MSB = 35;
   // reset values
   localparam logic [63:0]  PDC_VAL_LO_RST  = 64'h0;
   localparam logic [63:0]  PDC_VAL_HI_RST  = 64'h0;
   localparam logic [63:0]  PDC_MASK_LO_RST = 64'h0;
   localparam logic [63:0]  PDC_MASK_HI_RST = 64'h0;
endpackage : pdc_pkg
`default_nettype wire

// [pdc_split_reg.sv]
// one 64-bit msr at a parameter address; the whole word is kept as written, fields are cut by the user
`timescale 1ns/1ps
`default_nettype none
module pdc_split_reg
   import pdc_pkg::*;
#(
   parameter logic [31:0] ADDR  = 32'h0,
   parameter logic [63:0] RST   = 64'h0
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        msr_wr,
   input  wire logic [31:0] msr_addr,
   input  wire logic [63:0] msr_wdata,
   output logic             sel,
   output logic [63:0]      value_q
);
   logic [63:0] value_d;

   always_comb
   begin
      sel     = (msr_addr == ADDR);
      value_d = value_q;
      // reserved bits hold what software wrote so write-as-read returns it
      if (msr_wr && sel)
      begin
         value_d = msr_wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         value_q <= RST;
      end
      else
      begin
         value_q <= value_d;
      end
   end
endmodule : pdc_split_reg
`default_nettype wire

// [pdc_compare_trap.sv]
// packet data compare trap: compare registers and match logic on arbitrated packets
//
// Overview of operation
// - a hit is declared when the packet data ANDed with the assembled mask equals the assembled value.
// - only a packet that has won arbitration is compared, never one still waiting.
// - a hit drives only the data-compare error sources whose enables are set.
// - value bits 80 to 45 come from bits 35 to 0 of the high compare-value register.
// - mask bits 44 to 0 come from bits 44 to 0 of the low compare-mask register.
// - data, value and mask halves are joined into full 81-bit patterns before comparing.
// - mask bits 80 to 45 come from bits 35 to 0 of the high compare-mask register.
`timescale 1ns/1ps
`default_nettype none
module pdc_compare_trap
   import pdc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   msr_wr,
   input  wire logic                   msr_rd,
   input  wire logic [31:0]            msr_addr,
   input  wire logic [63:0]            msr_wdata,
   output logic      [63:0]            msr_rdata,
   output logic                        msr_hit,
   input  wire logic                   pkt_granted,
   input  wire logic [PDC_HALF_HI_W-1:0] incoming_packet_data_hi,
   input  wire logic [PDC_HALF_LO_W-1:0] incoming_packet_data_lo,
   input  wire logic [PDC_NUM_SRC-1:0] source_enable,
   output logic                        compare_hit_q,
   output logic      [PDC_NUM_SRC-1:0] data_match_error_source_q
);
   // stored register words and decodes
   logic [63:0]              val_lo_q;
   logic [63:0]              val_hi_q;
   logic [63:0]              mask_lo_q;
   logic [63:0]              mask_hi_q;
   logic [3:0]               sel;

   // fields cut out of the stored words
   logic [PDC_HALF_LO_W-1:0] compare_value_lower_field;
   logic [PDC_HALF_HI_W-1:0] compare_value_upper_field;
   logic [PDC_HALF_LO_W-1:0] compare_mask_lower_field;
   logic [PDC_HALF_HI_W-1:0] compare_mask_upper_field;

   // assembled patterns and match state
   logic [PDC_PAT_W-1:0]     incoming_packet_data;
   logic [PDC_PAT_W-1:0]     assembled_match_value;
   logic [PDC_PAT_W-1:0]     assembled_match_mask;
   logic [PDC_PAT_W-1:0]     masked_packet_data;
   logic                     hit_now;
   logic                     compare_hit_d;
   logic [PDC_NUM_SRC-1:0]   data_match_error_source_d;

   logic [63:0]              msr_rdata_d;
   logic [63:0]              msr_rdata_q;

   // write-as-read: the whole word is stored so reserved bits read back unchanged
   pdc_split_reg
   #(
      .ADDR (PDC_VAL_LO_ADDR),
      .RST  (PDC_VAL_LO_RST)
   )
   u_val_lo
   (
      .clk       (clk),
      .rst       (rst),
      .msr_wr    (msr_wr),
      .msr_addr  (msr_addr),
      .msr_wdata (msr_wdata),
      .sel       (sel[0]),
      .value_q   (val_lo_q)
   );

   // compare value, high word
   pdc_split_reg
   #(
      .ADDR (PDC_VAL_HI_ADDR),
      .RST  (PDC_VAL_HI_RST)
   )
   u_val_hi
   (
      .clk       (clk),
      .rst       (rst),
      .msr_wr    (msr_wr),
      .msr_addr  (msr_addr),
      .msr_wdata (msr_wdata),
      .sel       (sel[1]),
      .value_q   (val_hi_q)
   );

   // compare mask, low word
   pdc_split_reg
   #(
      .ADDR (PDC_MASK_LO_ADDR),
      .RST  (PDC_MASK_LO_RST)
   )
   u_mask_lo
   (
      .clk       (clk),
      .rst       (rst),
      .msr_wr    (msr_wr),
      .msr_addr  (msr_addr),
      .msr_wdata (msr_wdata),
      .sel       (sel[2]),
      .value_q   (mask_lo_q)
   );

   // compare mask, high word
   pdc_split_reg
   #(
      .ADDR (PDC_MASK_HI_ADDR),
      .RST  (PDC_MASK_HI_RST)
   )
   u_mask_hi
   (
      .clk       (clk),
      .rst       (rst),
      .msr_wr    (msr_wr),
      .msr_addr  (msr_addr),
      .msr_wdata (msr_wdata),
      .sel       (sel[3]),
      .value_q   (mask_hi_q)
   );

   // fields cut out of the stored words
   always_comb
   begin
      compare_value_upper_field = val_hi_q[PDC_HI_FIELD_MSB:0];
      compare_value_lower_field = val_lo_q[PDC_LO_FIELD_MSB:0];
      compare_mask_upper_field  = mask_hi_q[PDC_HI_FIELD_MSB:0];
      compare_mask_lower_field  = mask_lo_q[PDC_LO_FIELD_MSB:0];
   end

   always_comb
   begin
      incoming_packet_data  = {incoming_packet_data_hi, incoming_packet_data_lo};
      assembled_match_value = {compare_value_upper_field, compare_value_lower_field};
      assembled_match_mask  = {compare_mask_upper_field, compare_mask_lower_field};
   end

   // match of the packet on the port this cycle
   always_comb
   begin
      masked_packet_data        = incoming_packet_data & assembled_match_mask;
      hit_now                   = (masked_packet_data == assembled_match_value);
      compare_hit_d             = pkt_granted && hit_now;
      data_match_error_source_d = {PDC_NUM_SRC{compare_hit_d}} & source_enable;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         compare_hit_q             <= 1'b0;
         data_match_error_source_q <= '0;
      end
      else
      begin
         compare_hit_q             <= compare_hit_d;
         data_match_error_source_q <= data_match_error_source_d;
      end
   end

   // read mux: unmapped reads give zero, the last word stands until the next read
   always_comb
   begin
      msr_rdata_d = msr_rdata_q;
      if (msr_rd)
      begin
         case (sel)
            4'h1:
            begin
               msr_rdata_d = val_lo_q;
            end
            4'h2:
            begin
               msr_rdata_d = val_hi_q;
            end
            4'h4:
            begin
               msr_rdata_d = mask_lo_q;
            end
            4'h8:
            begin
               msr_rdata_d = mask_hi_q;
            end
            default:
            begin
               msr_rdata_d = 64'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         msr_rdata_q <= 64'h0;
      end
      else
      begin
         msr_rdata_q <= msr_rdata_d;
      end
   end

   assign msr_rdata = msr_rdata_q;

   // any of the four words decoded
   always_comb
   begin
      msr_hit = |sel;
   end
endmodule : pdc_compare_trap
`default_nettype wire

// [pdc_compare_trap_asserts.sv]
// port checker of the packet data compare trap
`timescale 1ns/1ps
`default_nettype none
module pdc_compare_trap_asserts
   import pdc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        msr_wr,
   input wire logic        msr_rd,
   input wire logic [31:0] msr_addr,
   input wire logic [63:0] msr_wdata,
   input wire logic [63:0] msr_rdata,
   input wire logic        msr_hit,
   input wire logic        pkt_granted,
   input wire logic [35:0] incoming_packet_data_hi,
   input wire logic [44:0] incoming_packet_data_lo,
   input wire logic [1:0]  source_enable,
   input wire logic        compare_hit_q,
   input wire logic [1:0]  data_match_error_source_q
);
   logic [80:0] val_q, msk_q;
   wire         match = pkt_granted && (({incoming_packet_data_hi, incoming_packet_data_lo} & msk_q) == val_q);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // shadow of the four compare fields
   always_ff @(posedge clk)
      if (rst) {val_q, msk_q} <= '0;
      else if (msr_wr && msr_addr[31:2] == PDC_VAL_LO_ADDR[31:2])
         case (msr_addr[1:0])
            2'h0: val_q[44:0] <= msr_wdata[44:0];
            2'h1: val_q[80:45] <= msr_wdata[35:0];
            2'h2: msk_q[44:0] <= msr_wdata[44:0];
            default: msk_q[80:45] <= msr_wdata[35:0];
         endcase
   sequence s_match;
      match;
   endsequence
   a_hit_on_match: assert property (s_match |=> compare_hit_q) else $error("hit missed");
   a_hit_cause: assert property (compare_hit_q |-> $past(match)) else $error("false hit");
   a_grant_only: assert property (!pkt_granted |=> !compare_hit_q) else $error("ungranted hit");
   a_src_enabled: assert property (compare_hit_q |->
      data_match_error_source_q == $past(source_enable)) else $error("bad source");
   a_src_quiet: assert property (!compare_hit_q |-> data_match_error_source_q == 2'h0) else $error("stray source");
   a_rd_unmapped: assert property (msr_rd && !msr_hit |=> msr_rdata == 64'h0) else $error("unmapped data");
   a_rd_holds: assert property (!msr_rd |=> $stable(msr_rdata)) else $error("read data moved");
endmodule : pdc_compare_trap_asserts
bind pdc_compare_trap pdc_compare_trap_asserts u_chk (.*);
`default_nettype wire

// [pdc_pkt_src.sv]
// arbiter-side model presenting packets
`timescale 1ns/1ps
`default_nettype none
module pdc_pkt_src
(
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [80:0] pat,
   output logic             pkt_granted = 1'h0,
   output logic [35:0]      incoming_packet_data_hi = '0,
   output logic [44:0]      incoming_packet_data_lo = '0
);
   always @(posedge clk) #2 {pkt_granted, incoming_packet_data_hi, incoming_packet_data_lo} = {go, pat};
endmodule : pdc_pkt_src
`default_nettype wire

// [pdc_compare_trap_tb_top.sv]
// self-checking bench of the packet data compare trap
`timescale 1ns/1ps
`default_nettype none
module pdc_compare_trap_tb_top
   import pdc_pkg::*;
;
   localparam logic [80:0] HIT = {36'ha000_0000, 45'h5a};
   localparam logic [63:0] WV [5] = '{64'h5a, 64'ha000_0000, 64'hff, 64'hf000_0000, 64'h1};
   localparam logic [86:0] ROWS [6] = '{{1'h1, HIT, 5'h1f}, {1'h1, HIT | 81'hf00 | 81'h1 << 80, 5'h0d},
      {1'h1, HIT ^ 81'h1, 5'h18}, {1'h1, HIT ^ 81'h1 << 76, 5'h18}, {1'h0, HIT, 5'h18}, {1'h1, HIT, 5'h16}};
   logic clk = 0, rst = 1, msr_wr = 0, msr_rd = 0, go = 0, msr_hit, pkt_granted, compare_hit_q;
   logic [2:0]  exp_hit;
   logic [31:0] msr_addr = '0;
   logic [63:0] msr_wdata = '0, msr_rdata;
   logic [80:0] pat = '0;
   logic [35:0] incoming_packet_data_hi;
   logic [44:0] incoming_packet_data_lo;
   logic [1:0]  source_enable = '0, data_match_error_source_q;
   int          miscompares = 0, cmp_count = 0;
   pdc_compare_trap u_pdc_compare_trap (.*);
   pdc_pkt_src u_pdc_pkt_src (.*);
   task automatic chk(input logic [63:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one register access; a read compares against d
   task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
      @(posedge clk) #1 {msr_wr, msr_rd, msr_addr, msr_wdata} = {w, !w, a, d};
      @(negedge clk) chk(msr_hit, a >= PDC_VAL_LO_ADDR && a <= PDC_MASK_HI_ADDR, "msr_hit");
      @(posedge clk) #1 {msr_wr, msr_rd} = 2'h0;
      if (!w) chk(msr_rdata, d, "rdata");
   endtask : acc
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial forever #5 clk = ~clk;
   initial
   begin
      #5000;
      miscompares++;
      end_sim;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst = 0;
      chk({compare_hit_q, data_match_error_source_q}, 3'h0, "hit");
      for (int i = 0; i < 5; i++)
         acc(1'h0, PDC_VAL_LO_ADDR + i, 64'h0);
      $display("test reset end");
      // each word written and read back; writes stay inside the fields, and the fifth, unmapped address reads zero
      for (int i = 0; i < 5; i++)
      begin
         acc(1'h1, PDC_VAL_LO_ADDR + i, WV[i]);
         acc(1'h0, PDC_VAL_LO_ADDR + i, i < 4 ? WV[i] : 64'h0);
      end
      $display("test regs end");
      foreach (ROWS[i])
      begin
         {go, pat, source_enable, exp_hit} = ROWS[i];
         repeat (2) @(posedge clk);
         #1 chk({compare_hit_q, data_match_error_source_q}, exp_hit, "hit");
      end
      $display("test rows end");
      rst = 1;
      @(posedge clk) #1 rst = 0;
      repeat (2) @(posedge clk);
      #1 chk({compare_hit_q, data_match_error_source_q}, 3'h6, "hit");
      acc(1'h0, PDC_MASK_HI_ADDR, 64'h0);
      $display("test run reset end");
      end_sim;
   end
endmodule : pdc_compare_trap_tb_top
`default_nettype wire
